// File: include/spc_pkg.sv
`default_nettype none
package spc_pkg;
  // Register offsets from the socket base address.
  localparam logic [11:0] SPC_ID_OFFSET = 12'h0800;
  localparam logic [11:0] SPC_PWR_OFFSET = 12'h0802;
  // Fields of the power control register.
  localparam int SPC_OE_BIT = 7;
  localparam int SPC_AUTO_BIT = 5;
  localparam int SPC_CAPWR_BIT = 4;
  localparam int SPC_VCC_LSB = 3;
  localparam int SPC_VPP_LSB = 0;
  localparam logic [7:0] SPC_PWR_RESET = 8'h00;
  // Bits that exist in each layout; all others read zero and ignore writes.
  localparam logic [7:0] SPC_ORIG_MASK = 8'hB3;
  localparam logic [7:0] SPC_REV_MASK = 8'h9B;
  // Bits kept over a host bus reset while wake is enabled.
  localparam logic [7:0] SPC_ORIG_STICKY = 8'h20;
  localparam logic [7:0] SPC_REV_STICKY = 8'h9B;
  // Fields of the identification register.
  localparam int SPC_REV_LSB = 0;
  localparam int SPC_SPARE_LSB = 4;
  localparam logic [1:0] SPC_IFTYPE = 2'h2;
  localparam logic [3:0] SPC_REV_RESET = 4'h4;
  localparam logic [3:0] SPC_REV_ORIG = 4'h2;
  localparam logic [1:0] SPC_SPARE_RESET = 2'h0;
  // Vcc and Vpp request codes.
  localparam logic [1:0] SPC_VCC_5V = 2'h2;
  localparam logic [1:0] SPC_VCC_3V3 = 2'h3;
  localparam logic [1:0] SPC_VPP_12V = 2'h2;
  localparam logic [1:0] SPC_VPP_VCC = 2'h1;
  typedef enum logic {SPC_LAYOUT_ORIG, SPC_LAYOUT_REV} spc_layout_t;
endpackage
`default_nettype wire

// File: hdl/spc_decode.sv
`timescale 1ns/1ps
`default_nettype none
module spc_decode (
  input wire logic [7:0] stored,
  input wire spc_pkg::spc_layout_t layout,
  input wire logic system_supply_select_bit,
  output logic oe,
  output logic auto_sw,
  output logic vcc_on,
  output logic vcc_3v3,
  output logic vpp_12v,
  output logic vpp_vcc
);
  logic [1:0] vcc_f;
  logic [1:0] vpp_f;
  always_comb begin
    vcc_f = stored[spc_pkg::SPC_VCC_LSB +: 2];
    vpp_f = stored[spc_pkg::SPC_VPP_LSB +: 2];
    oe = stored[spc_pkg::SPC_OE_BIT];
    if (layout == spc_pkg::SPC_LAYOUT_ORIG) begin
      auto_sw = stored[spc_pkg::SPC_AUTO_BIT];
      vcc_on = stored[spc_pkg::SPC_CAPWR_BIT];
      vcc_3v3 = vcc_on & system_supply_select_bit;
    end else begin
      auto_sw = 1'b0;
      vcc_on = (vcc_f == spc_pkg::SPC_VCC_5V) ||
        (vcc_f == spc_pkg::SPC_VCC_3V3);
      vcc_3v3 = (vcc_f == spc_pkg::SPC_VCC_3V3);
    end
    vpp_12v = vcc_on && (vpp_f == spc_pkg::SPC_VPP_12V);
    vpp_vcc = vcc_on && (vpp_f == spc_pkg::SPC_VPP_VCC);
  end
endmodule // spc_decode
`default_nettype wire

// File: hdl/spc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Bit 7 gates all 16-bit socket outputs; 0 disables them and is default.
// - Original layout: bit 6 is reserved and reads 0.
// - Original layout: bit 5 enables card-detect automatic power switching.
// - Original layout: bit 4 enables Vcc; voltage from system select bit.
// - Original layout: bits 3 and 2 are reserved and read 0.
// - Vpp field: 00 off, 10 12V, 01 equals Vcc, 11 off.
// - Vpp request is ignored unless socket Vcc is enabled.
// - Revised layout: bits 6 and 5 read 0 and writes change nothing.
// - Revised layout: Vcc field 00 off, 10 5V, 11 3.3V, 01 off.
// - Revised layout: bit 2 reads 0 and writes have no effect.
// - Wake on: marked bits clear only by global reset; else by either reset.
// - Revision field resets to 0100b; writing 0010b selects original layout.
// - Card power status reads 1 while socket power is on, else 0.
module spc_power_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic host_bus_reset_n,
  input wire logic pme_wake_enable,
  input wire logic system_supply_select_bit,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rd_ack_q,
  output logic socket_output_enable_q,
  output logic auto_power_switch_enable_q,
  output logic vcc_on_q,
  output logic vcc_3v3_q,
  output logic vpp_12v_q,
  output logic vpp_vcc_q,
  output logic card_power_status_q,
  output logic compat_original_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check.
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding.
  logic [7:0] pwr_q;
  logic [3:0] compat_revision_field_q;
  logic [1:0] spare_q;
  spc_pkg::spc_layout_t layout;
  logic hit_pwr;
  logic hit_id;
  logic [7:0] wmask;
  logic [7:0] sticky;
  logic dec_oe;
  logic dec_auto;
  logic dec_vcc_on;
  logic dec_vcc_3v3;
  logic dec_vpp_12v;
  logic dec_vpp_vcc;

  function automatic logic [7:0] layout_mask(spc_pkg::spc_layout_t l);
    return (l == spc_pkg::SPC_LAYOUT_ORIG) ? spc_pkg::SPC_ORIG_MASK :
      spc_pkg::SPC_REV_MASK;
  endfunction

  always_comb begin
    layout = (compat_revision_field_q == spc_pkg::SPC_REV_ORIG) ?
      spc_pkg::SPC_LAYOUT_ORIG : spc_pkg::SPC_LAYOUT_REV;
    hit_pwr = (reg_addr == ADDR_W'(spc_pkg::SPC_PWR_OFFSET));
    hit_id = (reg_addr == ADDR_W'(spc_pkg::SPC_ID_OFFSET));
    wmask = layout_mask(layout);
    sticky = (layout == spc_pkg::SPC_LAYOUT_ORIG) ?
      spc_pkg::SPC_ORIG_STICKY : spc_pkg::SPC_REV_STICKY;
  end

  spc_decode u_decode (
    .stored(pwr_q),
    .layout(layout),
    .system_supply_select_bit(system_supply_select_bit),
    .oe(dec_oe),
    .auto_sw(dec_auto),
    .vcc_on(dec_vcc_on),
    .vcc_3v3(dec_vcc_3v3),
    .vpp_12v(dec_vpp_12v),
    .vpp_vcc(dec_vpp_vcc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power control register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwr_q <= spc_pkg::SPC_PWR_RESET;
    end else if (!host_bus_reset_n) begin
      if (pme_wake_enable) begin
        pwr_q <= pwr_q & sticky;
      end else begin
        pwr_q <= spc_pkg::SPC_PWR_RESET;
      end
    end else if (reg_wr && hit_pwr) begin
      pwr_q <= (pwr_q & ~wmask) | (reg_wdata & wmask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification register, cleared only by the global reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      compat_revision_field_q <= spc_pkg::SPC_REV_RESET;
      spare_q <= spc_pkg::SPC_SPARE_RESET;
    end else if (reg_wr && hit_id) begin
      compat_revision_field_q <= reg_wdata[spc_pkg::SPC_REV_LSB +: 4];
      spare_q <= reg_wdata[spc_pkg::SPC_SPARE_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rd_ack_q <= 1'b0;
    end else begin
      reg_rd_ack_q <= reg_rd;
      if (reg_rd && hit_pwr) begin
        reg_rdata_q <= pwr_q & wmask;
      end else if (reg_rd && hit_id) begin
        reg_rdata_q <= {spc_pkg::SPC_IFTYPE, spare_q,
          compat_revision_field_q};
      end else if (reg_rd) begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Socket drive outputs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      socket_output_enable_q <= 1'b0;
      auto_power_switch_enable_q <= 1'b0;
      vcc_on_q <= 1'b0;
      vcc_3v3_q <= 1'b0;
      vpp_12v_q <= 1'b0;
      vpp_vcc_q <= 1'b0;
      card_power_status_q <= 1'b0;
      compat_original_q <= 1'b0;
    end else begin
      socket_output_enable_q <= dec_oe;
      auto_power_switch_enable_q <= dec_auto;
      vcc_on_q <= dec_vcc_on;
      vcc_3v3_q <= dec_vcc_3v3;
      vpp_12v_q <= dec_vpp_12v;
      vpp_vcc_q <= dec_vpp_vcc;
      card_power_status_q <= dec_vcc_on;
      compat_original_q <= (layout == spc_pkg::SPC_LAYOUT_ORIG);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic wr_pwr;
  logic rd_pwr;
  assign wr_pwr = reg_wr && hit_pwr;
  assign rd_pwr = reg_rd && hit_pwr;

  property p_oe_write;
    (wr_pwr && host_bus_reset_n) ##1 host_bus_reset_n |=>
      socket_output_enable_q == $past(reg_wdata[7], 2);
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("Output enable does not follow written bit 7.");

  property p_orig_bit6;
    (rd_pwr && layout == spc_pkg::SPC_LAYOUT_ORIG) |=> !reg_rdata_q[6];
  endproperty
  a_orig_bit6: assert property (p_orig_bit6)
    else $error("Bit 6 read nonzero in original layout.");

  property p_auto;
    ##1 auto_power_switch_enable_q ==
      $past(layout == spc_pkg::SPC_LAYOUT_ORIG && pwr_q[5]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("Auto switch output wrong for layout.");

  property p_orig_vcc;
    (layout == spc_pkg::SPC_LAYOUT_ORIG && pwr_q[4] &&
      system_supply_select_bit) |=> vcc_on_q && vcc_3v3_q;
  endproperty
  a_orig_vcc: assert property (p_orig_vcc)
    else $error("Original layout Vcc enable not applied.");

  property p_orig_rsvd;
    (rd_pwr && layout == spc_pkg::SPC_LAYOUT_ORIG) |=>
      reg_rdata_q[3:2] == 2'h0;
  endproperty
  a_orig_rsvd: assert property (p_orig_rsvd)
    else $error("Bits 3 and 2 read nonzero in original layout.");

  property p_vpp_gate;
    vpp_12v_q || vpp_vcc_q |-> vcc_on_q && !(vpp_12v_q && vpp_vcc_q);
  endproperty
  a_vpp_gate: assert property (p_vpp_gate)
    else $error("Vpp driven without Vcc.");

  property p_rev_rsvd;
    (wr_pwr && host_bus_reset_n && layout == spc_pkg::SPC_LAYOUT_REV) |=>
      pwr_q[6:5] == $past(pwr_q[6:5]) && pwr_q[2] == $past(pwr_q[2]);
  endproperty
  a_rev_rsvd: assert property (p_rev_rsvd)
    else $error("Reserved bit changed by a write in revised layout.");

  property p_rev_vcc_rsvd;
    (layout == spc_pkg::SPC_LAYOUT_REV && pwr_q[4:3] == 2'h1) |=> !vcc_on_q;
  endproperty
  a_rev_vcc_rsvd: assert property (p_rev_vcc_rsvd)
    else $error("Reserved Vcc code powered the socket.");

  property p_wake_keep;
    (!host_bus_reset_n && pme_wake_enable) |=>
      pwr_q[7] == $past(pwr_q[7] && layout == spc_pkg::SPC_LAYOUT_REV);
  endproperty
  a_wake_keep: assert property (p_wake_keep)
    else $error("Host bus reset handled wrongly for bit 7.");

  property p_rev_select;
    (reg_wr && hit_id && reg_wdata[3:0] == 4'h2) |=>
      layout == spc_pkg::SPC_LAYOUT_ORIG ##1 compat_original_q;
  endproperty
  a_rev_select: assert property (p_rev_select)
    else $error("Writing 0010b did not select original layout.");

  property p_status;
    ##1 card_power_status_q == $past(pwr_q[spc_pkg::SPC_CAPWR_BIT]);
  endproperty
  a_status: assert property (p_status)
    else $error("Card power status disagrees with socket Vcc.");

  property p_oe_off;
    !pwr_q[spc_pkg::SPC_OE_BIT] |=> !socket_output_enable_q;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Socket outputs enabled while bit 7 is clear.");

  property p_vpp_ignored;
    !pwr_q[spc_pkg::SPC_CAPWR_BIT] |=> !vpp_12v_q && !vpp_vcc_q;
  endproperty
  a_vpp_ignored: assert property (p_vpp_ignored)
    else $error("Vpp driven while Vcc request is off.");

  property p_rev_vpp_off;
    (layout == spc_pkg::SPC_LAYOUT_REV && pwr_q[1:0] == 2'h3) |=>
      !vpp_12v_q && !vpp_vcc_q;
  endproperty
  a_rev_vpp_off: assert property (p_rev_vpp_off)
    else $error("Vpp code 11 did not give 0 V in revised layout.");

  property p_rev_vcc_3v3;
    (layout == spc_pkg::SPC_LAYOUT_REV &&
      pwr_q[4:3] == spc_pkg::SPC_VCC_3V3) |=> vcc_on_q && vcc_3v3_q;
  endproperty
  a_rev_vcc_3v3: assert property (p_rev_vcc_3v3)
    else $error("Vcc code 11 did not give 3.3 V.");

  property p_rev_read_rsvd;
    (rd_pwr && layout == spc_pkg::SPC_LAYOUT_REV) |=>
      reg_rdata_q[6:5] == 2'h0 && !reg_rdata_q[2];
  endproperty
  a_rev_read_rsvd: assert property (p_rev_read_rsvd)
    else $error("Reserved bit read nonzero in revised layout.");

  property p_rev_auto_off;
    layout == spc_pkg::SPC_LAYOUT_REV |=> !auto_power_switch_enable_q;
  endproperty
  a_rev_auto_off: assert property (p_rev_auto_off)
    else $error("Auto switching enabled in revised layout.");

  property p_nowake_clear;
    (!host_bus_reset_n && !pme_wake_enable) |=>
      pwr_q == spc_pkg::SPC_PWR_RESET;
  endproperty
  a_nowake_clear: assert property (p_nowake_clear)
    else $error("Host bus reset without wake left power bits set.");

  property p_id_read;
    (reg_rd && hit_id) |=> reg_rdata_q[7:6] == spc_pkg::SPC_IFTYPE &&
      reg_rdata_q[3:0] == $past(compat_revision_field_q);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("Revision field read back wrongly.");

  property p_id_keep;
    (!host_bus_reset_n && !(reg_wr && hit_id)) |=>
      $stable(compat_revision_field_q);
  endproperty
  a_id_keep: assert property (p_id_keep)
    else $error("Host bus reset changed the revision field.");

  c_rev_5v: cover property (layout == spc_pkg::SPC_LAYOUT_REV ##1
    vcc_on_q && !vcc_3v3_q && vpp_12v_q);
  c_orig_auto: cover property (auto_power_switch_enable_q && vcc_on_q);
  c_wake_reset: cover property (!host_bus_reset_n && pme_wake_enable &&
    pwr_q[7]);
  c_vpp_ignored: cover property (pwr_q[1] && !pwr_q[4] ##1 !vpp_12v_q);
  c_orig_vpp_vcc: cover property (compat_original_q && vpp_vcc_q);

endmodule // spc_power_ctrl
`default_nettype wire

// File: tb/spc_socket_model.sv
`timescale 1ns/1ps
`default_nettype none
// Socket power switch and output buffers, in millivolts.
module spc_socket_model (
  input wire logic outputs_en,
  input wire logic vcc_on,
  input wire logic vcc_3v3,
  input wire logic vpp_12v,
  input wire logic vpp_vcc,
  output logic [15:0] vcc_mv,
  output logic [15:0] vpp_mv,
  output logic card_driven
);
  assign vcc_mv = !vcc_on ? 16'h0000 : (vcc_3v3 ? 16'h0ce4 : 16'h1388);
  assign vpp_mv = vpp_12v ? 16'h2ee0 : (vpp_vcc ? vcc_mv : 16'h0000);
  assign card_driven = outputs_en;
endmodule // spc_socket_model
`default_nettype wire

// File: tb/spc_power_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spc_power_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hbr_n = 1'b1;
  logic wake = 1'b0;
  logic ssb = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic ack, oe, auto_sw, vcc_on, v33, vpp12, vppvcc, cps, orig, driven;
  logic [15:0] vcc_mv, vpp_mv;
  logic [15:0] outs;
  int failures = 0;
  int n_compared = 0;
  assign outs = {9'h000, oe, auto_sw, vcc_on, v33, vpp12, vppvcc, cps};
  always #5 clk_sys = ~clk_sys;
  spc_power_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_bus_reset_n(hbr_n), .pme_wake_enable(wake),
    .system_supply_select_bit(ssb), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata),
    .reg_rd_ack_q(ack), .socket_output_enable_q(oe),
    .auto_power_switch_enable_q(auto_sw), .vcc_on_q(vcc_on),
    .vcc_3v3_q(v33), .vpp_12v_q(vpp12), .vpp_vcc_q(vppvcc),
    .card_power_status_q(cps), .compat_original_q(orig));
  spc_socket_model u_socket (.outputs_en(oe), .vcc_on(vcc_on),
    .vcc_3v3(v33), .vpp_12v(vpp12), .vpp_vcc(vppvcc), .vcc_mv(vcc_mv),
    .vpp_mv(vpp_mv), .card_driven(driven));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk("ack", 16'h0001, {15'h0000, ack});
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic wr_out(input logic [7:0] d, input logic [7:0] e);
    wr_reg(12'h802, d);
    tick(1);
    chk("outs", {8'h00, e}, outs);
  endtask
  task automatic host_reset;
    hbr_n = 1'b0;
    tick(1);
    hbr_n = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(12'h802, 8'h00);
    rd_chk(12'h800, 8'h84);
    chk("outs", 16'h0000, outs);
    chk("orig", 16'h0000, {15'h0000, orig});
    rd_chk(12'h805, 8'h00);
  endtask
  task automatic t_rev_codes;
    logic on;
    for (int i = 0; i < 4; i++) begin
      on = (i >= 2);
      wr_out({3'b100, i[1:0], 3'b010},
        {2'b01, 1'b0, on, i == 3, on, 1'b0, on});
      chk("vcc_mv", !on ? 16'h0000 : (i == 3 ? 16'h0ce4 : 16'h1388),
        vcc_mv);
      chk("driven", 16'h0001, {15'h0000, driven});
    end
    for (int j = 0; j < 4; j++) begin
      wr_out({6'b100100, j[1:0]},
        {4'b0101, 1'b0, j == 2, j == 1, 1'b1});
    end
    wr_out(8'hff, 8'h59);
    rd_chk(12'h802, 8'h9b);
  endtask
  task automatic t_host_reset;
    wake = 1'b1;
    host_reset();
    rd_chk(12'h802, 8'h9b);
    wake = 1'b0;
    host_reset();
    rd_chk(12'h802, 8'h00);
  endtask
  task automatic t_orig;
    wr_reg(12'h800, 8'h02);
    rd_chk(12'h800, 8'h82);
    chk("orig", 16'h0001, {15'h0000, orig});
    ssb = 1'b1;
    wr_out(8'hff, 8'h79);
    rd_chk(12'h802, 8'hb3);
    ssb = 1'b0;
    wr_out(8'h91, 8'h53);
    chk("vpp_mv", 16'h1388, vpp_mv);
    wr_out(8'h82, 8'h40);
    wr_reg(12'h802, 8'hb3);
    wake = 1'b1;
    host_reset();
    rd_chk(12'h802, 8'h20);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    end_sim();
  end
  initial begin
    tick(12);
    rst_n = 1'b1;
    t_reset();
    t_rev_codes();
    t_host_reset();
    t_orig();
    end_sim();
  end
endmodule // spc_power_ctrl_tb
`default_nettype wire
